// >>> core/uca_channel.sv
// Per-channel aux logic: slow timer, clock routing, multidrop filter, direction control, triggering
// Operation
// - Timer divides baud clock by 1024*divisor
// - Timer output is 50% duty square wave
// - Enabled timer drives the channel's pin 1
// - Sync register bit routes reference clock to pin 0
// - Multidrop: eight data bits plus address/data ninth bit
// - Multidrop drops parity, flags received address words
// - Filtering needs multidrop and special-char enable both
// - Address from register or upper nibble plus pins
// - Pin address follows synchronised pin levels continuously
// - Store data after matching address, drop otherwise
// - Filtering never stores address words
// - Direction goes high when enabled transmitter has data
// - Direction rises setup period before data
// - Direction holds high hold period after end
// - Transmitter assigned one of 16 trigger commands
// - Global command applies to every channel
// - Trigger starts only disabled transmitter with data
// - Programmable delay after trigger before start
// - Intrinsic trigger delay about 0/16 to 1/16
`timescale 1ns/10ps
`include "uca_map.svh"

module uca_channel #(
	parameter int TICKS_PER_BIT = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic baud_tick_i,
	input wire logic ref_clk_lvl_i,
	input wire logic [7:0] slow_timer_low_i,
	input wire logic [7:0] slow_timer_high_i,
	input wire logic [7:0] transmit_sync_control_i,
	input wire logic [7:0] first_mode_register_i,
	input wire logic [7:0] second_mode_register_i,
	input wire logic [7:0] second_stop_char_register_i,
	input wire logic [7:0] flow_control_register_i,
	input wire logic [7:0] half_duplex_delay_register_i,
	input wire logic [7:0] sync_delay_low_i,
	input wire logic [7:0] sync_delay_high_i,
	input wire logic global_cmd_wr_i,
	input wire logic [7:0] global_command_register_i,
	input wire logic [3:0] gpio_i,
	input wire logic [3:0] gpio_out_i,
	input wire logic [3:0] gpio_oe_i,
	input wire uca_pkg::uca_rx_word_t rx_word_i,
	input wire logic tx_fifo_nonempty_i,
	input wire logic tx_busy_i,
	output logic [3:0] gpio_o,
	output logic [3:0] gpio_oe_o,
	output logic fifo_wr_o,
	output logic [7:0] fifo_data_o,
	output logic fifo_parity_err_o,
	output logic address_received_flag_o,
	output logic tx_go_o,
	output logic direction_o,
	output logic tx_auto_disabled_o
);

	localparam logic [7:0] TPB = 8'(TICKS_PER_BIT);

	uca_pkg::uca_state_t s_r;
	uca_pkg::uca_state_t s_nxt;

	logic tmr_en;
	logic [14:0] tmr_div;
	logic [23:0] tmr_half;
	logic mdrop;
	logic filt_en;
	logic [7:0] station_addr;
	logic dir_en;
	logic txdis;
	logic tx_enabled;
	logic tx_has_work;
	logic trig_hit;
	logic tx_done;

	function automatic logic [11:0] bit_ticks(input logic [3:0] n, input logic [7:0] tpb);
		bit_ticks = 12'(n) * 12'(tpb);
	endfunction

	always_comb begin
		s_nxt = s_r;
		tmr_en = slow_timer_high_i[`UCA_TMR_EN_BIT];
		tmr_div = {slow_timer_high_i[6:0], slow_timer_low_i};
		tmr_half = {tmr_div, 9'h000};
		mdrop = second_mode_register_i[`UCA_SECOND_MODE_REGISTER_MDROP_BIT];
		filt_en = mdrop && second_mode_register_i[`UCA_SECOND_MODE_REGISTER_SPCL_BIT];
		dir_en = first_mode_register_i[`UCA_FIRST_MODE_REGISTER_DIR_BIT];
		txdis = first_mode_register_i[`UCA_FIRST_MODE_REGISTER_TXDIS_BIT];

		// Pin synchroniser
		s_nxt.meta_r = gpio_i;
		s_nxt.sync_r = s_r.meta_r;

		// Station address, follows pins live
		if (flow_control_register_i[`UCA_FLOW_PINADDR_BIT]) begin
			station_addr = {second_stop_char_register_i[7:4], s_r.sync_r};
		end else begin
			station_addr = second_stop_char_register_i;
		end

		// Slow timer: toggle every 512*div baud ticks
		if (!tmr_en || tmr_div == 15'h0000) begin
			s_nxt.tmr_cnt_r = 24'h000000;
			s_nxt.tmr_out_r = 1'b0;
		end else if (baud_tick_i) begin
			if (s_r.tmr_cnt_r >= tmr_half - 24'h000001) begin
				s_nxt.tmr_cnt_r = 24'h000000;
				s_nxt.tmr_out_r = !s_r.tmr_out_r;
			end else begin
				s_nxt.tmr_cnt_r = s_r.tmr_cnt_r + 24'h000001;
			end
		end

		// Receive path
		s_nxt.fifo_wr_r = 1'b0;
		s_nxt.addr_flag_r = 1'b0;
		if (rx_word_i.valid) begin
			s_nxt.fifo_data_r = rx_word_i.data;
			s_nxt.fifo_perr_r = mdrop ? 1'b0 : rx_word_i.parity_err;
			if (mdrop && rx_word_i.ninth) begin
				s_nxt.addr_flag_r = 1'b1;
				if (filt_en) begin
					s_nxt.addressed_r = (rx_word_i.data == station_addr);
					s_nxt.fifo_wr_r = 1'b0;
				end else begin
					s_nxt.fifo_wr_r = 1'b1;
				end
			end else if (filt_en) begin
				s_nxt.fifo_wr_r = s_r.addressed_r;
			end else begin
				s_nxt.fifo_wr_r = 1'b1;
			end
		end
		if (!filt_en) begin
			s_nxt.addressed_r = 1'b0;
		end

		// Auto transmit disable and its release
		s_nxt.txdis_prev_r = txdis;
		s_nxt.busy_prev_r = tx_busy_i;
		tx_done = s_r.busy_prev_r && !tx_busy_i && !tx_fifo_nonempty_i;
		if (!transmit_sync_control_i[`UCA_SYNC_AUTODIS_BIT]) begin
			s_nxt.auto_dis_r = 1'b0;
		end else if (tx_done) begin
			s_nxt.auto_dis_r = 1'b1;
		end else if (txdis != s_r.txdis_prev_r) begin
			s_nxt.auto_dis_r = 1'b0;
		end
		tx_enabled = (!txdis && !s_r.auto_dis_r) || s_r.trig_rel_r;

		// Trigger command, same for every channel
		trig_hit = global_cmd_wr_i && transmit_sync_control_i[`UCA_SYNC_TRIGEN_BIT]
			&& global_command_register_i[7:4] == `UCA_TRIG_BASE
			&& global_command_register_i[3:0] == transmit_sync_control_i[3:0];
		if (trig_hit && (txdis || s_r.auto_dis_r) && tx_fifo_nonempty_i && !s_r.trig_rel_r) begin
			s_nxt.trig_wait_r = 1'b1;
			s_nxt.trig_cnt_r = {sync_delay_high_i, sync_delay_low_i};
		end else if (s_r.trig_wait_r && baud_tick_i) begin
			if (s_r.trig_cnt_r == 16'h0000) begin
				s_nxt.trig_wait_r = 1'b0;
				s_nxt.trig_rel_r = 1'b1;
			end else begin
				s_nxt.trig_cnt_r = s_r.trig_cnt_r - 16'h0001;
			end
		end
		if (s_r.trig_rel_r && tx_done) begin
			s_nxt.trig_rel_r = 1'b0;
		end

		tx_has_work = tx_fifo_nonempty_i && tx_enabled;

		// Direction control
		case (s_r.dir_r)
			uca_pkg::DIR_IDLE: begin
				if (tx_has_work) begin
					if (dir_en && half_duplex_delay_register_i[7:4] != 4'h0) begin
						s_nxt.dir_r = uca_pkg::DIR_SETUP;
						s_nxt.dir_cnt_r = bit_ticks(half_duplex_delay_register_i[7:4], TPB);
					end else begin
						s_nxt.dir_r = uca_pkg::DIR_SEND;
					end
				end
			end
			uca_pkg::DIR_SETUP: begin
				if (baud_tick_i) begin
					if (s_r.dir_cnt_r <= 12'h001) begin
						s_nxt.dir_r = uca_pkg::DIR_SEND;
					end else begin
						s_nxt.dir_cnt_r = s_r.dir_cnt_r - 12'h001;
					end
				end
			end
			uca_pkg::DIR_SEND: begin
				if (!tx_busy_i && !tx_has_work) begin
					if (dir_en && half_duplex_delay_register_i[3:0] != 4'h0) begin
						s_nxt.dir_r = uca_pkg::DIR_HOLD;
						s_nxt.dir_cnt_r = bit_ticks(half_duplex_delay_register_i[3:0], TPB);
					end else begin
						s_nxt.dir_r = uca_pkg::DIR_IDLE;
					end
				end
			end
			uca_pkg::DIR_HOLD: begin
				if (tx_has_work) begin
					s_nxt.dir_r = uca_pkg::DIR_SEND;
				end else if (baud_tick_i) begin
					if (s_r.dir_cnt_r <= 12'h001) begin
						s_nxt.dir_r = uca_pkg::DIR_IDLE;
					end else begin
						s_nxt.dir_cnt_r = s_r.dir_cnt_r - 12'h001;
					end
				end
			end
			default: begin
				s_nxt.dir_r = uca_pkg::DIR_IDLE;
			end
		endcase

		if (rst_i) begin
			s_nxt = '0;
			s_nxt.dir_r = uca_pkg::DIR_IDLE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		s_r <= s_nxt;
	end

	// Pin muxing
	always_comb begin
		gpio_o = gpio_out_i;
		gpio_oe_o = gpio_oe_i;
		if (transmit_sync_control_i[`UCA_SYNC_REFCLK_BIT]) begin
			gpio_o[`UCA_PIN_REFCLK] = ref_clk_lvl_i;
			gpio_oe_o[`UCA_PIN_REFCLK] = 1'b1;
		end
		if (slow_timer_high_i[`UCA_TMR_EN_BIT]) begin
			gpio_o[`UCA_PIN_TIMER] = s_r.tmr_out_r;
			gpio_oe_o[`UCA_PIN_TIMER] = 1'b1;
		end
	end

	assign fifo_wr_o = s_r.fifo_wr_r;
	assign fifo_data_o = s_r.fifo_data_r;
	assign fifo_parity_err_o = s_r.fifo_perr_r;
	assign address_received_flag_o = s_r.addr_flag_r;
	assign tx_go_o = (s_r.dir_r == uca_pkg::DIR_SEND) && (tx_enabled || tx_busy_i);
	assign direction_o = first_mode_register_i[`UCA_FIRST_MODE_REGISTER_DIR_BIT] && (s_r.dir_r != uca_pkg::DIR_IDLE);
	assign tx_auto_disabled_o = s_r.auto_dis_r;

endmodule

// >>> include/uca_map.svh
// Field positions, pin indices, reset values and timing counts of the channel aux block
`ifndef UCA_MAP_SVH
`define UCA_MAP_SVH
`define UCA_TMR_MULT_LOG2 10
`define UCA_TMR_HALF_W 24
`define UCA_TMR_EN_BIT 7
`define UCA_FIRST_MODE_REGISTER_TXDIS_BIT 1
`define UCA_FIRST_MODE_REGISTER_DIR_BIT 4
`define UCA_SECOND_MODE_REGISTER_SPCL_BIT 4
`define UCA_SECOND_MODE_REGISTER_MDROP_BIT 6
`define UCA_FLOW_PINADDR_BIT 2
`define UCA_SYNC_AUTODIS_BIT 4
`define UCA_SYNC_REFCLK_BIT 5
`define UCA_SYNC_TRIGEN_BIT 6
`define UCA_TRIG_BASE 4'hE
`define UCA_TICKS_PER_BIT 8'h10
`define UCA_PIN_REFCLK 0
`define UCA_PIN_TIMER 1
`define UCA_RST_BYTE 8'h00
`endif

// >>> include/uca_pkg.sv
// Types of the channel aux block
package uca_pkg;
	typedef enum logic [3:0] {
		DIR_IDLE = 4'h1,
		DIR_SETUP = 4'h2,
		DIR_SEND = 4'h4,
		DIR_HOLD = 4'h8
	} uca_dir_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic ninth;
		logic parity_err;
	} uca_rx_word_t;

	typedef struct packed {
		logic [3:0] meta_r;
		logic [3:0] sync_r;
		logic [23:0] tmr_cnt_r;
		logic tmr_out_r;
		logic addressed_r;
		logic fifo_wr_r;
		logic [7:0] fifo_data_r;
		logic fifo_perr_r;
		logic addr_flag_r;
		uca_dir_t dir_r;
		logic [11:0] dir_cnt_r;
		logic trig_wait_r;
		logic [15:0] trig_cnt_r;
		logic trig_rel_r;
		logic auto_dis_r;
		logic txdis_prev_r;
		logic busy_prev_r;
	} uca_state_t;
endpackage

// >>> verification/uca_channel_props.sv
// Port assertions of the channel aux block
`timescale 1ns/10ps
module uca_channel_props #(
	parameter int TICKS_PER_BIT = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic ref_clk_lvl_i,
	input wire logic [7:0] transmit_sync_control_i,
	input wire logic [7:0] first_mode_register_i,
	input wire logic [7:0] second_mode_register_i,
	input wire logic [7:0] half_duplex_delay_register_i,
	input wire logic [3:0] gpio_out_i,
	input wire logic [3:0] gpio_oe_i,
	input wire uca_pkg::uca_rx_word_t rx_word_i,
	input wire logic [3:0] gpio_o,
	input wire logic [3:0] gpio_oe_o,
	input wire logic fifo_wr_o,
	input wire logic [7:0] fifo_data_o,
	input wire logic fifo_parity_err_o,
	input wire logic address_received_flag_o,
	input wire logic tx_go_o,
	input wire logic direction_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire logic md = second_mode_register_i[6];
	wire logic filt = md & second_mode_register_i[4];
	wire logic addr = rx_word_i.valid & rx_word_i.ninth;
	property p_flag; addr && md |=> address_received_flag_o; endproperty
	a_flag: assert property (p_flag) else $error("address flag missing");
	property p_perr; fifo_wr_o && $past(md) |-> !fifo_parity_err_o; endproperty
	a_perr: assert property (p_perr) else $error("parity kept in multidrop");
	property p_noaddr; addr && filt |=> !fifo_wr_o; endproperty
	a_noaddr: assert property (p_noaddr) else $error("address word stored");
	property p_pass; rx_word_i.valid && !md |=> fifo_wr_o && fifo_data_o == $past(rx_word_i.data); endproperty
	a_pass: assert property (p_pass) else $error("plain word not stored");
	property p_ref; transmit_sync_control_i[5] |-> gpio_o[0] == ref_clk_lvl_i && gpio_oe_o[0]; endproperty
	a_ref: assert property (p_ref) else $error("reference clock not routed");
	property p_keep; !transmit_sync_control_i[5] |-> {gpio_o[0], gpio_oe_o[0]} == {gpio_out_i[0], gpio_oe_i[0]}; endproperty
	a_keep: assert property (p_keep) else $error("pin 0 not ordinary");
	property p_setup; $rose(direction_o) && half_duplex_delay_register_i[7:4] != 4'h0 |-> !tx_go_o [*8]; endproperty
	a_setup: assert property (p_setup) else $error("setup period skipped");
	property p_dir; tx_go_o && first_mode_register_i[4] |-> direction_o; endproperty
	a_dir: assert property (p_dir) else $error("direction low while sending");
	c_wr: cover property (filt && fifo_wr_o);
	c_go: cover property (tx_go_o && direction_o);
	c_flag: cover property (address_received_flag_o);
endmodule

bind uca_channel uca_channel_props #(.TICKS_PER_BIT(TICKS_PER_BIT)) u_props (.sys_clk_i, .rst_i, .ref_clk_lvl_i,
	.transmit_sync_control_i, .first_mode_register_i, .second_mode_register_i, .half_duplex_delay_register_i,
	.gpio_out_i, .gpio_oe_i, .rx_word_i, .gpio_o, .gpio_oe_o, .fifo_wr_o, .fifo_data_o, .fifo_parity_err_o,
	.address_received_flag_o, .tx_go_o, .direction_o);

// >>> verification/uca_tx_model.sv
// Transmitter and transmit FIFO model beside the channel aux block
`timescale 1ns/10ps
module uca_tx_model (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic tx_go_i,
	output logic tx_busy_o,
	output logic nonempty_o
);
	int words;
	int left;
	assign nonempty_o = words > 0;
	assign tx_busy_o = left > 0;
	// Sends only while allowed, frames of two bit times
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			words <= 0;
			left <= 0;
		end else if (left > 0) begin
			left <= left - 1;
		end else if (tx_go_i && words > 0) begin
			left <= 32;
			words <= words - 1;
		end else begin
			words <= words + int'(load_i);
		end
	end
endmodule

// >>> verification/testbench.sv
// Self-checking testbench of the channel aux block
`timescale 1ns/10ps
module testbench;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic refc = 1'b0;
	logic cmd_wr = 1'b0;
	logic load = 1'b0;
	logic [7:0] r [0:10] = '{default: 8'h00};
	logic tick = 1'b1;
	logic [3:0] gin = 4'h0;
	uca_pkg::uca_rx_word_t rx = '0;
	logic nonempty, busy, go, dir, wr, perr, flag, adis;
	logic [3:0] gpo, gpoe;
	logic [7:0] fdata, last;
	int fail_count = 0;
	int checks_done = 0;
	int wr_n = 0;
	int fl_n = 0;
	int n;
	uca_channel uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .baud_tick_i(tick), .ref_clk_lvl_i(refc),
		.slow_timer_low_i(r[0]), .slow_timer_high_i(r[1]), .transmit_sync_control_i(r[2]),
		.first_mode_register_i(r[3]), .second_mode_register_i(r[4]), .second_stop_char_register_i(r[5]),
		.flow_control_register_i(r[6]), .half_duplex_delay_register_i(r[7]), .sync_delay_low_i(r[8]),
		.sync_delay_high_i(r[10]), .global_cmd_wr_i(cmd_wr), .global_command_register_i(r[9]), .gpio_i(gin),
		.gpio_out_i(4'h5), .gpio_oe_i(4'hC), .rx_word_i(rx), .tx_fifo_nonempty_i(nonempty), .tx_busy_i(busy),
		.gpio_o(gpo), .gpio_oe_o(gpoe), .fifo_wr_o(wr), .fifo_data_o(fdata), .fifo_parity_err_o(perr),
		.address_received_flag_o(flag), .tx_go_o(go), .direction_o(dir), .tx_auto_disabled_o(adis));
	uca_tx_model u_tx (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_i(load), .tx_go_i(go), .tx_busy_o(busy),
		.nonempty_o(nonempty));
	initial forever #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		refc <= ~refc;
		if (flag === 1'b1) begin
			fl_n <= fl_n + 1;
		end
		if (wr === 1'b1) begin
			wr_n <= wr_n + 1;
			last <= fdata;
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task step(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask
	// Bounded wait on direction, go or timer pin
	task waitv(input int s, input logic v);
		n = 0;
		while ((s == 0 ? dir : s == 1 ? go : gpo[1]) !== v) begin
			step(1);
			n++;
			if (n > 3000) begin
				fail_count++;
				print_verdict;
			end
		end
	endtask
	task send(input logic [7:0] d, input logic nine);
		@(posedge sys_clk_i) rx <= '{1'b1, d, nine, 1'b1};
		@(posedge sys_clk_i) rx <= '0;
	endtask
	task cmd(input logic [7:0] v);
		@(posedge sys_clk_i) begin
			cmd_wr <= 1'b1;
			r[9] <= v;
		end
		@(posedge sys_clk_i) cmd_wr <= 1'b0;
		step(0);
	endtask
	task t_pins;
		@(posedge sys_clk_i) r[2] <= 8'h20;
		step(1);
		chk({14'h0, gpo[0], gpoe[0]}, {14'h0, refc, 1'b1});
		@(posedge sys_clk_i) r[2] <= 8'h00;
		step(1);
		chk({8'h0, gpo, gpoe}, 16'h005C);
	endtask
	task t_drop;
		send(8'h77, 1'b0);
		@(posedge sys_clk_i) begin
			r[4] <= 8'h50;
			r[5] <= 8'h5A;
			r[6] <= 8'h04;
			gin <= 4'h3;
		end
		step(4);
		chk({15'h0, perr}, 16'h0001);
		send(8'h53, 1'b1);
		send(8'h11, 1'b0);
		send(8'h5A, 1'b1);
		send(8'h22, 1'b0);
		@(posedge sys_clk_i) gin <= 4'hA;
		step(4);
		send(8'h5A, 1'b1);
		send(8'h33, 1'b0);
		step(2);
		chk(16'(wr_n), 16'h0003);
		chk({8'h0, last}, 16'h0033);
		chk({15'h0, perr}, 16'h0000);
		chk(16'(fl_n), 16'h0003);
	endtask
	task t_tmr;
		@(posedge sys_clk_i) begin
			tick <= 1'b0;
			r[0] <= 8'h01;
		end
		@(posedge sys_clk_i) r[1] <= 8'h80;
		step(600);
		chk({14'h0, gpo[1], gpoe[1]}, 16'h0001);
		@(posedge sys_clk_i) tick <= 1'b1;
		step(1);
		waitv(2, 1'b1);
		waitv(2, 1'b0);
		chk(16'(n), 16'h0200);
		waitv(2, 1'b1);
		chk(16'(n), 16'h0200);
	endtask
	task t_dir;
		@(posedge sys_clk_i) begin
			r[3] <= 8'h10;
			r[7] <= 8'h11;
			load <= 1'b1;
		end
		@(posedge sys_clk_i) load <= 1'b0;
		step(0);
		waitv(0, 1'b1);
		waitv(1, 1'b1);
		chk(16'(n >= 15 && n <= 18), 16'h0001);
		waitv(1, 1'b0);
		waitv(0, 1'b0);
		chk(16'(n >= 15 && n <= 18), 16'h0001);
	endtask
	task t_trig;
		for (int k = 0; k < 16; k++) begin
			@(posedge sys_clk_i) begin
				r[3] <= 8'h02;
				r[2] <= 8'h40 | 8'(k);
				r[8] <= 8'(k);
			end
			cmd(8'hE0 | 8'(k));
			@(posedge sys_clk_i) load <= 1'b1;
			@(posedge sys_clk_i) load <= 1'b0;
			step(20);
			chk({15'h0, go}, 16'h0000);
			cmd(8'hE0 | 8'((k + 1) % 16));
			step(20);
			chk({15'h0, go}, 16'h0000);
			cmd(8'hE0 | 8'(k));
			waitv(1, 1'b1);
			chk(16'(n), 16'(k + 2));
			waitv(1, 1'b0);
		end
	endtask
	task t_adis;
		@(posedge sys_clk_i) begin
			r[3] <= 8'h00;
			r[2] <= 8'h10;
			load <= 1'b1;
		end
		@(posedge sys_clk_i) load <= 1'b0;
		step(0);
		waitv(1, 1'b1);
		waitv(1, 1'b0);
		chk({15'h0, adis}, 16'h0001);
		@(posedge sys_clk_i) load <= 1'b1;
		@(posedge sys_clk_i) load <= 1'b0;
		step(20);
		chk({14'h0, go, nonempty}, 16'h0001);
		@(posedge sys_clk_i) r[3] <= 8'h02;
		@(posedge sys_clk_i) r[3] <= 8'h00;
		waitv(1, 1'b1);
		chk({15'h0, adis}, 16'h0000);
		waitv(1, 1'b0);
		chk({15'h0, adis}, 16'h0001);
		@(posedge sys_clk_i) r[2] <= 8'h00;
		step(2);
		chk({15'h0, adis}, 16'h0000);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		step(3);
		t_pins;
		t_drop;
		t_tmr;
		t_dir;
		t_trig;
		t_adis;
		print_verdict;
	end
endmodule
